// [rtl/hwg_pkg.sv]
package hwg_pkg;

    // clock
    localparam int CLK_NS = 20;

    // widths
    localparam int DEV_AW = 9;
    localparam int DEV_DW = 16;
    localparam int REG_DW = 32;
    localparam int SW_AW = 5;
    localparam int CNT_W = 5;
    localparam int PH_W = 2;

    // device register map (byte addresses on the device side)
    localparam logic [DEV_AW-1:0] DEV_FIFO_END = 9'h050;
    localparam logic [DEV_AW-1:0] DEV_INTR_CFG = 9'h054;
    localparam logic [DEV_AW-1:0] DEV_INTR_STATUS = 9'h058;
    localparam logic [DEV_AW-1:0] DEV_INTR_EN = 9'h05C;
    localparam logic [DEV_AW-1:0] DEV_BYTE_ORDER = 9'h064;
    localparam logic [DEV_AW-1:0] DEV_FIFO_LEVEL_INT = 9'h068;
    localparam logic [DEV_AW-1:0] DEV_TXFIFO_INFO = 9'h080;

    // write-to-read spacing, in ns as given
    localparam int HOST_CYCLE_TIME_NS = 45;
    localparam int T_ANY_NS = 45;
    localparam int T_TXFIFO_NS = 135;
    localparam int T_CFG_CFG_NS = 60;
    localparam int T_EN_CFG_NS = 90;
    localparam int T_EN_STAT_NS = 60;
    localparam int T_STAT_CFG_NS = 180;
    localparam int T_STAT_STAT_NS = 170;
    localparam int T_LVL_CFG_NS = 90;
    localparam int T_LVL_STAT_NS = 80;

    // same spacings as whole clock cycles, rounded up
    localparam int T_ANY_CYC = (T_ANY_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_TXFIFO_CYC = (T_TXFIFO_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_CFG_CFG_CYC = (T_CFG_CFG_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_EN_CFG_CYC = (T_EN_CFG_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_EN_STAT_CYC = (T_EN_STAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_STAT_CFG_CYC = (T_STAT_CFG_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_STAT_STAT_CYC = (T_STAT_STAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_LVL_CFG_CYC = (T_LVL_CFG_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_LVL_STAT_CYC = (T_LVL_STAT_NS + CLK_NS - 1) / CLK_NS;

    // device word access: strobes low in phases 1..2 on the pins, 4 clocks in all
    localparam logic [PH_W-1:0] ACC_STROBE_END = 2'h2;
    localparam logic [PH_W-1:0] ACC_SAMPLE_PH = 2'h2;
    localparam logic [PH_W-1:0] ACC_LAST_PH = 2'h3;

    // software register offsets
    localparam logic [SW_AW-1:0] SW_CTRL = 5'h00;
    localparam logic [SW_AW-1:0] SW_ADDR = 5'h04;
    localparam logic [SW_AW-1:0] SW_WDATA = 5'h08;
    localparam logic [SW_AW-1:0] SW_CMD = 5'h0C;
    localparam logic [SW_AW-1:0] SW_RDATA = 5'h10;
    localparam logic [SW_AW-1:0] SW_STATUS = 5'h14;

    // field positions
    localparam int CTRL_DUMMY_BIT = 0;
    localparam int CMD_READ_BIT = 0;
    localparam int CMD_HBCFG_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_STALL_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_DROP_BIT = 3;
    localparam int ST_DUMMY_LSB = 8;
    localparam int ST_REQ_LSB = 16;

    // reset values
    localparam logic CTRL_DUMMY_RST = 1'b0;

    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic dataOe;
        logic [DEV_AW-1:0] addr;
        logic [DEV_DW-1:0] dataOut;
    } hwg_devbus_s;

endpackage

// [rtl/hwg_elapsed_counter.sv]
`timescale 1ns/1ps
// counts clocks since the last clear and sticks at its top value
module hwg_elapsed_counter #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    // state
    output logic [W-1:0] count
);

    logic [W-1:0] count_q;

    // reset to the top so the first read after reset is not held back
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_q <= '1;
        end else if (clear) begin
            count_q <= '0;
        end else if (count_q != '1) begin
            count_q <= count_q + W'(1);
        end
    end

    assign count = count_q;

endmodule

// [rtl/hwg_host_spacing_guard.sv]
`timescale 1ns/1ps
// How it works
// R1 - any write: 45 ns or one dummy read
// R2 - transmit FIFO write: 135 ns before information read
// R3 - interrupt config write: 60 ns before readback
// R4 - enable write: 90 ns config, 60 status
// R5 - status write: 180 ns config, 170 status
// R6 - level write: 90 ns config, 80 status
// R7 - dummy reads of byte-order register fill spacing
// R8 - slower cycles need fewer dummies, same time
// R9 - any delay means is allowed, dummies optional
// R10 - no delay added when time already passed
// R11 - spacing starts after the final word written
// R12 - host bus index/config accesses need no wait
// R13 - spacing rounded up to clocks, read stalled
module hwg_host_spacing_guard (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // software register port
    input wire logic [hwg_pkg::SW_AW-1:0] swAddr,
    input wire logic [hwg_pkg::REG_DW-1:0] swWrData,
    input wire logic swWr,
    input wire logic swRd,
    output logic [hwg_pkg::REG_DW-1:0] swRdData,
    // device host bus pins
    output hwg_pkg::hwg_devbus_s devOut,
    input wire logic [hwg_pkg::DEV_DW-1:0] devDataIn
);

    typedef enum logic [1:0] {
        IDLE,
        HOLD,
        DUMMY,
        WORD
    } hwg_state_e;

    // required spacing in clocks for a read of rdA after a write of wrA
    function automatic logic [hwg_pkg::CNT_W-1:0] spacingCycles(
        input logic [hwg_pkg::DEV_AW-1:0] wrA,
        input logic [hwg_pkg::DEV_AW-1:0] rdA
    );
        int c;
        c = hwg_pkg::T_ANY_CYC; // [R1]
        // the affected set is unknown here, so every read pays the base spacing
        if (wrA < hwg_pkg::DEV_FIFO_END && rdA == hwg_pkg::DEV_TXFIFO_INFO) begin
            c = hwg_pkg::T_TXFIFO_CYC; // [R2]
        end else if (wrA == hwg_pkg::DEV_INTR_CFG && rdA == hwg_pkg::DEV_INTR_CFG) begin
            c = hwg_pkg::T_CFG_CFG_CYC; // [R3]
        end else if (wrA == hwg_pkg::DEV_INTR_EN) begin
            if (rdA == hwg_pkg::DEV_INTR_CFG) begin
                c = hwg_pkg::T_EN_CFG_CYC; // [R4]
            end else if (rdA == hwg_pkg::DEV_INTR_STATUS) begin
                c = hwg_pkg::T_EN_STAT_CYC; // [R4]
            end
        end else if (wrA == hwg_pkg::DEV_INTR_STATUS) begin
            if (rdA == hwg_pkg::DEV_INTR_CFG) begin
                c = hwg_pkg::T_STAT_CFG_CYC; // [R5]
            end else if (rdA == hwg_pkg::DEV_INTR_STATUS) begin
                c = hwg_pkg::T_STAT_STAT_CYC; // [R5]
            end
        end else if (wrA == hwg_pkg::DEV_FIFO_LEVEL_INT) begin
            if (rdA == hwg_pkg::DEV_INTR_CFG) begin
                c = hwg_pkg::T_LVL_CFG_CYC; // [R6]
            end else if (rdA == hwg_pkg::DEV_INTR_STATUS) begin
                c = hwg_pkg::T_LVL_STAT_CYC; // [R6]
            end
        end
        return c[hwg_pkg::CNT_W-1:0];
    endfunction

    function automatic logic swHit(
        input logic [hwg_pkg::SW_AW-1:0] a,
        input logic [hwg_pkg::SW_AW-1:0] off
    );
        return a == off;
    endfunction

    hwg_state_e state_q;
    logic dummyMode_q;
    logic [hwg_pkg::DEV_AW-1:0] addr_q;
    logic [hwg_pkg::REG_DW-1:0] wrData_q;
    logic [hwg_pkg::REG_DW-1:0] rdData_q;
    logic cmdRead_q;
    logic cmdHbCfg_q;
    logic wordIdx_q;
    logic [hwg_pkg::PH_W-1:0] phase_q;
    logic [7:0] dummyCnt_q;
    logic [hwg_pkg::DEV_AW-1:0] lastWrAddr_q;
    logic done_q;
    logic drop_q;
    logic [hwg_pkg::REG_DW-1:0] swRdData_q;
    hwg_pkg::hwg_devbus_s devOut_q;

    logic [hwg_pkg::CNT_W-1:0] elapsed;
    logic [hwg_pkg::CNT_W-1:0] reqCyc;
    logic spacingMet;
    logic cmdWr;
    logic accessEnd;
    logic lastWordEnd;
    logic wrDone;
    logic strobeOn;
    logic statusRd;

    assign cmdWr = swWr && swHit(swAddr, hwg_pkg::SW_CMD);
    assign statusRd = swRd && swHit(swAddr, hwg_pkg::SW_STATUS);
    assign accessEnd = (state_q == WORD || state_q == DUMMY) && phase_q == hwg_pkg::ACC_LAST_PH;
    assign lastWordEnd = state_q == WORD && accessEnd && wordIdx_q;
    // a half-written register starts no spacing; only the closing word does
    assign wrDone = lastWordEnd && !cmdRead_q && !cmdHbCfg_q; // [R11] [R12]

    // index and configuration accesses of the bus interface skip the check
    assign reqCyc = cmdHbCfg_q ? '0 : spacingCycles(lastWrAddr_q, addr_q); // [R12] [R13]
    assign spacingMet = elapsed >= reqCyc; // [R10] [R13]

    // cleared only by a closing write word, so reads and dummies never restart the wait
    hwg_elapsed_counter #(
        .W(hwg_pkg::CNT_W)
    ) u_elapsed (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(wrDone),
        .count(elapsed)
    );

    // software control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dummyMode_q <= hwg_pkg::CTRL_DUMMY_RST;
            addr_q <= '0;
            wrData_q <= '0;
        end else if (swWr) begin
            // operands stay frozen while a command runs
            if (swHit(swAddr, hwg_pkg::SW_CTRL)) begin
                dummyMode_q <= swWrData[hwg_pkg::CTRL_DUMMY_BIT]; // [R9]
            end else if (swHit(swAddr, hwg_pkg::SW_ADDR) && state_q == IDLE) begin
                addr_q <= swWrData[hwg_pkg::DEV_AW-1:0];
            end else if (swHit(swAddr, hwg_pkg::SW_WDATA) && state_q == IDLE) begin
                wrData_q <= swWrData;
            end
        end
    end

    // command sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= IDLE;
            cmdRead_q <= 1'b0;
            cmdHbCfg_q <= 1'b0;
            wordIdx_q <= 1'b0;
            phase_q <= '0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (cmdWr) begin
                        cmdRead_q <= swWrData[hwg_pkg::CMD_READ_BIT];
                        cmdHbCfg_q <= swWrData[hwg_pkg::CMD_HBCFG_BIT];
                        wordIdx_q <= 1'b0;
                        phase_q <= '0;
                        state_q <= swWrData[hwg_pkg::CMD_READ_BIT] ? HOLD : WORD;
                    end
                end
                HOLD: begin
                    // the elapsed count runs on while held, so a plain wait ends by itself
                    phase_q <= '0;
                    if (spacingMet) begin
                        state_q <= WORD; // [R10]
                    end else if (dummyMode_q) begin
                        state_q <= DUMMY; // [R7]
                    end
                end
                DUMMY: begin
                    phase_q <= phase_q + hwg_pkg::PH_W'(1);
                    // re-check after each dummy: a slow access may already cover it
                    if (accessEnd) begin
                        state_q <= HOLD; // [R8]
                    end
                end
                WORD: begin
                    phase_q <= phase_q + hwg_pkg::PH_W'(1);
                    if (accessEnd) begin
                        wordIdx_q <= 1'b1;
                        if (wordIdx_q) begin
                            state_q <= IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // last write target, used to pick the spacing of the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lastWrAddr_q <= hwg_pkg::DEV_BYTE_ORDER;
        end else if (wrDone) begin
            lastWrAddr_q <= addr_q; // [R11]
        end
    end

    // read data assembled low word first
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData_q <= '0;
        end else if (state_q == WORD && cmdRead_q && phase_q == hwg_pkg::ACC_SAMPLE_PH) begin
            if (wordIdx_q) begin
                rdData_q[hwg_pkg::REG_DW-1:hwg_pkg::DEV_DW] <= devDataIn;
            end else begin
                rdData_q[hwg_pkg::DEV_DW-1:0] <= devDataIn;
            end
        end
    end

    // dummy read count of the current command
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dummyCnt_q <= '0;
        end else if (state_q == IDLE && cmdWr) begin
            dummyCnt_q <= '0;
        end else if (state_q == DUMMY && accessEnd && dummyCnt_q != '1) begin
            dummyCnt_q <= dummyCnt_q + 8'h01; // [R7]
        end
    end

    // sticky flags; a new event wins over the clear by a status read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            if (lastWordEnd) begin
                done_q <= 1'b1;
            end else if (statusRd || (state_q == IDLE && cmdWr)) begin
                done_q <= 1'b0;
            end
            if (cmdWr && state_q != IDLE) begin
                drop_q <= 1'b1;
            end else if (statusRd) begin
                drop_q <= 1'b0;
            end
        end
    end

    // device pins, registered one clock behind the phase count
    assign strobeOn = (state_q == WORD || state_q == DUMMY) && phase_q < hwg_pkg::ACC_STROBE_END;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            devOut_q.csN <= 1'b1;
            devOut_q.rdN <= 1'b1;
            devOut_q.wrN <= 1'b1;
            devOut_q.dataOe <= 1'b0;
            devOut_q.addr <= '0;
            devOut_q.dataOut <= '0;
        end else begin
            devOut_q.csN <= !strobeOn;
            devOut_q.rdN <= !(strobeOn && (state_q == DUMMY || cmdRead_q));
            devOut_q.wrN <= !(strobeOn && state_q == WORD && !cmdRead_q);
            devOut_q.dataOe <= strobeOn && state_q == WORD && !cmdRead_q;
            if (strobeOn) begin
                if (state_q == DUMMY) begin
                    devOut_q.addr <= hwg_pkg::DEV_BYTE_ORDER; // [R7]
                end else begin
                    devOut_q.addr <= {addr_q[hwg_pkg::DEV_AW-1:2], wordIdx_q, 1'b0};
                end
                // data also moves on reads; harmless, since the drive enable is low then
                devOut_q.dataOut <= wordIdx_q ? wrData_q[hwg_pkg::REG_DW-1:hwg_pkg::DEV_DW]
                                              : wrData_q[hwg_pkg::DEV_DW-1:0];
            end
        end
    end

    assign devOut = devOut_q;

    // software read port, data in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            swRdData_q <= '0;
        end else if (swRd) begin
            swRdData_q <= '0;
            if (swHit(swAddr, hwg_pkg::SW_CTRL)) begin
                swRdData_q[hwg_pkg::CTRL_DUMMY_BIT] <= dummyMode_q;
            end else if (swHit(swAddr, hwg_pkg::SW_ADDR)) begin
                swRdData_q[hwg_pkg::DEV_AW-1:0] <= addr_q;
            end else if (swHit(swAddr, hwg_pkg::SW_WDATA)) begin
                swRdData_q <= wrData_q;
            end else if (swHit(swAddr, hwg_pkg::SW_RDATA)) begin
                swRdData_q <= rdData_q;
            end else if (swHit(swAddr, hwg_pkg::SW_STATUS)) begin
                swRdData_q[hwg_pkg::ST_BUSY_BIT] <= state_q != IDLE;
                swRdData_q[hwg_pkg::ST_STALL_BIT] <= state_q == HOLD || state_q == DUMMY;
                swRdData_q[hwg_pkg::ST_DONE_BIT] <= done_q;
                swRdData_q[hwg_pkg::ST_DROP_BIT] <= drop_q;
                swRdData_q[hwg_pkg::ST_DUMMY_LSB +: 8] <= dummyCnt_q;
                swRdData_q[hwg_pkg::ST_REQ_LSB +: hwg_pkg::CNT_W] <= reqCyc;
            end
        end
    end

    assign swRdData = swRdData_q;

endmodule

// [test/hwg_guard_props.sv]
`timescale 1ns/1ps
module hwg_guard_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // software port
    input wire logic [hwg_pkg::SW_AW-1:0] swAddr,
    input wire logic [hwg_pkg::REG_DW-1:0] swWrData,
    input wire logic swWr,
    input wire logic swRd,
    input wire logic [hwg_pkg::REG_DW-1:0] swRdData,
    // device pins
    input wire hwg_pkg::hwg_devbus_s devOut,
    input wire logic [hwg_pkg::DEV_DW-1:0] devDataIn
);
    logic [7:0] gap_q;
    logic [8:0] lastWr_q;
    logic exempt_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // exempt host-bus commands neither start nor wait out a spacing
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            exempt_q <= 1'b0;
        end else if (swWr && swAddr == hwg_pkg::SW_CMD) begin
            exempt_q <= swWrData[hwg_pkg::CMD_HBCFG_BIT];
        end
    end
    // clocks since the write strobe last rose; saturates so reset means long ago
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gap_q <= 8'hFF;
            lastWr_q <= 9'h000;
        end else if (!devOut.wrN && !exempt_q) begin
            gap_q <= 8'h00;
            lastWr_q <= devOut.addr & 9'h1FC;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    function automatic int reqNs(input logic [8:0] w, input logic [8:0] r);
        if (w < hwg_pkg::DEV_FIFO_END && r == hwg_pkg::DEV_TXFIFO_INFO) return hwg_pkg::T_TXFIFO_NS;
        case ({w, r})
            {hwg_pkg::DEV_INTR_CFG, hwg_pkg::DEV_INTR_CFG}: return hwg_pkg::T_CFG_CFG_NS;
            {hwg_pkg::DEV_INTR_EN, hwg_pkg::DEV_INTR_CFG}: return hwg_pkg::T_EN_CFG_NS;
            {hwg_pkg::DEV_INTR_EN, hwg_pkg::DEV_INTR_STATUS}: return hwg_pkg::T_EN_STAT_NS;
            {hwg_pkg::DEV_INTR_STATUS, hwg_pkg::DEV_INTR_CFG}: return hwg_pkg::T_STAT_CFG_NS;
            {hwg_pkg::DEV_INTR_STATUS, hwg_pkg::DEV_INTR_STATUS}: return hwg_pkg::T_STAT_STAT_NS;
            {hwg_pkg::DEV_FIFO_LEVEL_INT, hwg_pkg::DEV_INTR_CFG}: return hwg_pkg::T_LVL_CFG_NS;
            {hwg_pkg::DEV_FIFO_LEVEL_INT, hwg_pkg::DEV_INTR_STATUS}: return hwg_pkg::T_LVL_STAT_NS;
            default: return hwg_pkg::T_ANY_NS;
        endcase
    endfunction
    sequence s_low_two(sig);
        !sig ##1 sig;
    endsequence
    a_write_pulse: assert property ($fell(devOut.wrN) |=> s_low_two(devOut.wrN))
        else $error("write strobe not two cycles");
    a_read_pulse: assert property ($fell(devOut.rdN) |=> s_low_two(devOut.rdN))
        else $error("read strobe not two cycles");
    a_cs_qualifies: assert property ((!devOut.rdN || !devOut.wrN) |-> !devOut.csN)
        else $error("strobe without chip select");
    a_oe_direction: assert property ((!devOut.rdN || !devOut.wrN) |-> devOut.dataOe == !devOut.wrN)
        else $error("data drive enable wrong");
    a_addr_stable: assert property ((!devOut.csN && $past(!devOut.csN)) |-> $stable(devOut.addr))
        else $error("address moved during access");
    a_write_pair: assert property ($fell(devOut.wrN) && !devOut.addr[1] |-> ##4
        (!devOut.wrN && devOut.addr == ($past(devOut.addr, 4) | 9'h002)))
        else $error("high word write missing");
    a_read_pair: assert property ($fell(devOut.rdN) && !devOut.addr[1]
        && devOut.addr != hwg_pkg::DEV_BYTE_ORDER |-> ##4
        (!devOut.rdN && devOut.addr == ($past(devOut.addr, 4) | 9'h002)))
        else $error("high word read missing");
    a_read_spacing: assert property ($fell(devOut.rdN) && !exempt_q && !devOut.addr[1]
        && devOut.addr != hwg_pkg::DEV_BYTE_ORDER
        |-> int'(gap_q) * hwg_pkg::CLK_NS >= reqNs(lastWr_q, devOut.addr))
        else $error("read issued too soon after write");
    a_empty_reads: assert property (swRd && (swAddr == hwg_pkg::SW_CMD || swAddr > hwg_pkg::SW_STATUS)
        |=> swRdData == 32'h0000_0000)
        else $error("write-only or unmapped read not zero");
endmodule
bind hwg_host_spacing_guard hwg_guard_props chk_u (.mclk(mclk), .rst_n(rst_n), .swAddr(swAddr),
    .swWrData(swWrData), .swWr(swWr), .swRd(swRd), .swRdData(swRdData), .devOut(devOut),
    .devDataIn(devDataIn));

// [test/hwg_dev_model.sv]
`timescale 1ns/1ps
module hwg_dev_model (
    // clock
    input wire logic mclk,
    // host bus pins
    input wire hwg_pkg::hwg_devbus_s devOut,
    output logic [hwg_pkg::DEV_DW-1:0] devDataIn
);
    logic [15:0] pend [0:255];
    logic [15:0] prev [0:255];
    realtime readyAt [0:255];
    logic wrSeen;
    logic rdSeen;
    initial begin
        for (int i = 0; i < 256; i++) begin
            pend[i] = 16'h0000;
            prev[i] = 16'h0000;
            readyAt[i] = 0.0;
        end
        wrSeen = 1'b0;
        rdSeen = 1'b0;
        devDataIn = 16'h0000;
    end
    // an early read sees the old value, so a host that does not wait reads stale data
    function automatic logic [15:0] visible(input int k, input realtime t);
        return (t >= readyAt[k]) ? pend[k] : prev[k];
    endfunction
    function automatic realtime settleNs(input logic [8:0] a);
        if (a[8:2] == hwg_pkg::DEV_INTR_CFG[8:2]) return hwg_pkg::T_CFG_CFG_NS;
        if (a[8:2] == hwg_pkg::DEV_INTR_STATUS[8:2]) return hwg_pkg::T_STAT_STAT_NS;
        return hwg_pkg::T_ANY_NS;
    endfunction
    // the last low sample of a write is the edge where its strobe rises
    always @(posedge mclk) begin : wr_side
        int k;
        k = int'(devOut.addr[8:1]);
        if (!devOut.csN && !devOut.wrN) begin
            if (!wrSeen) prev[k] = visible(k, $realtime);
            pend[k] = devOut.dataOut;
            readyAt[k] = $realtime + settleNs(devOut.addr);
            wrSeen = 1'b1;
        end else begin
            wrSeen = 1'b0;
        end
    end
    // the read strobe fell half a clock before this edge; released bus toggles
    always @(negedge mclk) begin
        if (!devOut.csN && !devOut.rdN) begin
            if (!rdSeen) devDataIn <= visible(int'(devOut.addr[8:1]), $realtime - 10.0);
            rdSeen = 1'b1;
        end else begin
            devDataIn <= ~devDataIn;
            rdSeen = 1'b0;
        end
    end
endmodule

// [test/test_host_write_read_spacing_guard.sv]
`timescale 1ns/1ps
module test_host_write_read_spacing_guard;
    logic mclk;
    logic rst_n;
    logic [hwg_pkg::SW_AW-1:0] swAddr;
    logic [hwg_pkg::REG_DW-1:0] swWrData;
    logic swWr;
    logic swRd;
    logic [hwg_pkg::REG_DW-1:0] swRdData;
    hwg_pkg::hwg_devbus_s devOut;
    logic [hwg_pkg::DEV_DW-1:0] devDataIn;
    logic [31:0] seed;
    logic [31:0] shadow [0:127];
    logic [31:0] st;
    logic [31:0] got;
    logic [8:0] wrTab [0:8];
    logic [8:0] rdTab [0:8];
    int nsTab [0:8];
    int nErrors;
    int numChecks;
    int req;
    logic [8:0] lastAddr;
    hwg_host_spacing_guard dut_u (.mclk(mclk), .rst_n(rst_n), .swAddr(swAddr),
        .swWrData(swWrData), .swWr(swWr), .swRd(swRd), .swRdData(swRdData),
        .devOut(devOut), .devDataIn(devDataIn));
    hwg_dev_model dev_u (.mclk(mclk), .devOut(devOut), .devDataIn(devDataIn));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic summarize();
        if (nErrors == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic swWrite(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        swWr <= 1'b1;
        swAddr <= a;
        swWrData <= v;
        @(posedge mclk);
        swWr <= 1'b0;
    endtask
    task automatic swRead(input logic [4:0] a, output logic [31:0] v);
        @(posedge mclk);
        swRd <= 1'b1;
        swAddr <= a;
        @(posedge mclk);
        swRd <= 1'b0;
        #1 v = swRdData;
    endtask
    task automatic devCmd(input logic [8:0] a, input logic [31:0] cmd, input logic [31:0] wd);
        // an unchanged target skips the address write, so the read follows sooner
        if (a !== lastAddr) swWrite(hwg_pkg::SW_ADDR, {23'h00_0000, a});
        lastAddr = a;
        if (!cmd[hwg_pkg::CMD_READ_BIT]) swWrite(hwg_pkg::SW_WDATA, wd);
        swWrite(hwg_pkg::SW_CMD, cmd);
        for (int n = 0; n < 300; n++) begin
            swRead(hwg_pkg::SW_STATUS, st);
            if (st[hwg_pkg::ST_DONE_BIT] === 1'b1) return;
        end
        nErrors++;
        summarize();
    endtask
    initial begin
        rst_n = 1'b0;
        swWr = 1'b0;
        swRd = 1'b0;
        swAddr = 5'h00;
        swWrData = 32'h0000_0000;
        seed = 32'h0000_89DE;
        nErrors = 0;
        numChecks = 0;
        lastAddr = 9'h1FF;
        for (int i = 0; i < 128; i++) shadow[i] = 32'h0000_0000;
        // write, then dependent read, with the spacing each pair needs
        wrTab = '{9'h010, 9'h054, 9'h05C, 9'h05C, 9'h058, 9'h058, 9'h068, 9'h068, 9'h070};
        rdTab = '{9'h080, 9'h054, 9'h054, 9'h058, 9'h054, 9'h058, 9'h054, 9'h058, 9'h070};
        nsTab = '{135, 60, 90, 60, 180, 170, 90, 80, 45};
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        swRead(hwg_pkg::SW_CTRL, got);
        check("ctrl reset", {31'h0000_0000, hwg_pkg::CTRL_DUMMY_RST}, got);
        swRead(5'h1C, got);
        check("unmapped read", 32'h0000_0000, got);
        for (int m = 0; m < 2; m++) begin
            swWrite(hwg_pkg::SW_CTRL, 32'(m));
            for (int k = 0; k < 9; k++) begin
                seed = xorshift(seed);
                devCmd(wrTab[k], 32'h0000_0000, seed);
                shadow[wrTab[k][8:2]] = seed;
                devCmd(rdTab[k], 32'h0000_0001, 32'h0000_0000);
                swRead(hwg_pkg::SW_RDATA, got);
                check("read data", shadow[rdTab[k][8:2]], got);
                swRead(hwg_pkg::SW_STATUS, st);
                req = (nsTab[k] + hwg_pkg::CLK_NS - 1) / hwg_pkg::CLK_NS;
                check("spacing clocks", 32'(req), {27'h000_0000, st[20:16]});
                if (m == 0) begin
                    check("idle wait dummies", 32'h0000_0000, {24'h00_0000, st[15:8]});
                end else if (req == 9) begin
                    check("dummies issued", 32'h0000_0001, {31'h0000_0000, st[15:8] != 8'h00});
                end else if (req <= 3) begin
                    check("no extra delay", 32'h0000_0000, {24'h00_0000, st[15:8]});
                end
            end
        end
        // host-bus configuration access right after a slow write must not wait
        seed = xorshift(seed);
        devCmd(hwg_pkg::DEV_INTR_STATUS, 32'h0000_0000, seed);
        devCmd(hwg_pkg::DEV_INTR_CFG, 32'h0000_0003, 32'h0000_0000);
        swRead(hwg_pkg::SW_STATUS, st);
        check("exempt dummies", 32'h0000_0000, {24'h00_0000, st[15:8]});
        // operands and a command sent while busy are refused; drop stays until read
        seed = xorshift(seed);
        swWrite(hwg_pkg::SW_WDATA, seed);
        swWrite(hwg_pkg::SW_CMD, 32'h0000_0000);
        swWrite(hwg_pkg::SW_WDATA, ~seed);
        swWrite(hwg_pkg::SW_CMD, 32'h0000_0000);
        swRead(hwg_pkg::SW_STATUS, st);
        check("busy and drop", 32'h0000_0009, {28'h000_0000, st[3:0]});
        swRead(hwg_pkg::SW_WDATA, got);
        check("wdata kept", seed, got);
        swRead(hwg_pkg::SW_CMD, got);
        check("cmd reads zero", 32'h0000_0000, got);
        swRead(hwg_pkg::SW_STATUS, st);
        check("done drop cleared", 32'h0000_0004, {28'h000_0000, st[3:0]});
        summarize();
    end
endmodule
